// ===== core/pll_ctl_pkg.sv
// Notes on behaviour
// - Multiplier field value zero gives a multiply factor of one.
// - Multiplier field values two through fifteen give that same factor.
// - Reset loads the multiplier field with six.
// - Multiplier field writes are ignored while the PLL enable bit is one.
// - VCO range field sets the range multiplier; writes blocked while enabled.
// - Range field zero disables the PLL and forces base-clock select low.
// - Reset loads the VCO range field with six.
// - Base-clock select cannot be set while all range bits are zero.
// - In automatic mode every lock change may raise an interrupt, gated by enable.
// - The lock-change flag sets on every lock change whatever the enable.
// - Manual mode suppresses requests and the flag reads as zero.
// - VCO may be selected while unlocked; software checks lock first.
// - Wait mode leaves all clock generator state untouched.
// - Oscillator enable low drops loop activity and holds the clock outputs and interrupt request low.
// - Stop entry clears base-clock select, which stays clear afterwards.
// - In break with clear enable zero, accesses leave the flag alone.
// - In break with clear enable one, a clearing read clears the flag.
// - Automatic mode sets the tracking bit once within tracking tolerance.
// - Automatic mode sets the lock indicator once within lock tolerance.
// - A read of the control register clears the lock-change flag, except in break with clear enable zero or when a lock change falls in the same cycle.
// - Enable cannot clear while select is one; select cannot set while off.
// - Base clock output runs at half the selected source frequency.
package pll_ctl_pkg;

	// ==========================================================
	// Register map: printed offsets are indices, byte address = 4 * index
	localparam logic [7:0] CTRL_IDX = 8'h1C;
	localparam logic [7:0] BWC_IDX = 8'h1D;
	localparam logic [7:0] PROG_IDX = 8'h1E;
	localparam logic [7:0] STAT_IDX = 8'h20;
	localparam int ADDR_W = 10;

	// ==========================================================
	// Field positions
	localparam int CTRL_IE_BIT = 7;
	localparam int CTRL_FLAG_BIT = 6;
	localparam int CTRL_EN_BIT = 5;
	localparam int CTRL_BCS_BIT = 4;
	localparam logic [3:0] CTRL_LOW_RD = 4'hF;
	localparam int BWC_AUTO_BIT = 7;
	localparam int BWC_LOCK_BIT = 6;
	localparam int BWC_ACQ_BIT = 5;
	localparam int BWC_XLD_BIT = 4;
	localparam int PROG_MUL_LSB = 4;
	localparam int PROG_VRS_LSB = 0;

	// ==========================================================
	// Reset values
	localparam logic [3:0] MUL_RST = 4'h6;
	localparam logic [3:0] VRS_RST = 4'h6;
	localparam logic EN_RST = 1'b1;

	// ==========================================================
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Control register contents
	typedef struct packed {
		logic irq_en;
		logic flag;
		logic pll_en;
		logic base_clock_select;
	} pll_ctrl_s;

	// Program register contents
	typedef struct packed {
		logic [3:0] mul;
		logic [3:0] vrs;
	} pll_prog_s;

endpackage

// ===== core/pll_ctl.sv
`timescale 1ns/10ps
module pll_ctl
	import pll_ctl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic oscillator_enable_in,
	input wire logic break_state_in,
	input wire logic break_clear_enable,
	input wire logic vco_clock,
	input wire logic within_tracking_tol,
	input wire logic within_lock_tol,
	output logic [3:0] feedback_multiplier,
	output logic [3:0] vco_range_out,
	output logic pll_active,
	output logic crystal_clock_gate,
	output logic base_clock_out,
	output logic pll_irq_request
);

	// ==========================================================
	// Helpers
	// Registers sit one to a word; the index is the byte address over four.
	// Only the low byte of each word carries fields, the rest reads zero.
	// Unmapped indices answer with an error code and change nothing.
	// A write with byte lane zero disabled is taken and answered, but ignored.
	// The factor helper keeps a zero field from reaching the divider as zero.
	// Multiply factor seen by the feedback divider
	function automatic logic [3:0] vco_factor(input logic [3:0] field);
		vco_factor = (field == 4'h0) ? 4'h1 : field;
	endfunction

	// Register index from a byte address
	function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
		reg_index = addr[ADDR_W-1:2];
	endfunction

	// Known register index
	function automatic logic mapped(input logic [7:0] idx);
		mapped = (idx == CTRL_IDX) || (idx == BWC_IDX) || (idx == PROG_IDX)
			|| (idx == STAT_IDX);
	endfunction

	// ==========================================================
	// Pin synchronisers: vco, tracking, lock
	// These three arrive from the analog loop, outside the bus clock.
	// Stage one may go metastable, so only stage two reads it.
	// The filtered copy moves only when stages two and three agree,
	// which rejects single-cycle glitches on the tolerance comparators.
	// Cost: about five clocks of delay from pin to status bit.
	logic [2:0] pin_s1_r;
	logic [2:0] pin_s2_r;
	logic [2:0] pin_s3_r;
	logic [2:0] pin_f_r;

	// Three stages, filtered value moves when stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_r <= 3'h0;
			pin_s2_r <= 3'h0;
			pin_s3_r <= 3'h0;
			pin_f_r <= 3'h0;
		end else begin
			pin_s1_r <= {vco_clock, within_tracking_tol, within_lock_tol};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			for (int i = 0; i < 3; i++) begin
				if (pin_s2_r[i] == pin_s3_r[i]) begin
					pin_f_r[i] <= pin_s3_r[i];
				end
			end
		end
	end

	// ==========================================================
	// State
	pll_ctrl_s ctrl_r;
	pll_prog_s prog_r;
	logic auto_r;
	logic acq_man_r;
	logic track_r;
	logic lock_r;
	logic lock_d_r;
	logic xld_r;
	logic osc_d_r;
	logic vco_d_r;
	logic half_r;

	// Bus handshake state
	logic aw_held_r;
	logic w_held_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic wstrb0_r;
	logic do_write;
	logic do_read;
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic wr_ctrl;
	logic wr_bwc;
	logic wr_prog;
	logic rd_clear;
	logic lock_change;
	logic stop_entry;
	logic [31:0] rd_value;

	// Ready lines are combinational from held state only, never from valid,
	// so no loop forms with a master that waits for ready.
	// Address and data may come in either order; each is held until both are in.
	// No new write is taken while a response still waits for the master.
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready = !w_held_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign wr_idx = reg_index(awaddr_r);
	assign rd_idx = reg_index(s_axi_araddr);
	assign wr_ctrl = do_write && wstrb0_r && (wr_idx == CTRL_IDX);
	assign wr_bwc = do_write && wstrb0_r && (wr_idx == BWC_IDX);
	assign wr_prog = do_write && wstrb0_r && (wr_idx == PROG_IDX);

	// Read of control register clears the flag unless break protects it
	assign rd_clear = do_read && (rd_idx == CTRL_IDX)
		&& (!break_state_in || break_clear_enable);
	assign lock_change = auto_r && (lock_r != lock_d_r);
	assign stop_entry = osc_d_r && !oscillator_enable_in;

	// Address and data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0;
			wstrb0_r <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb0_r <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_held_r <= 1'b0;
			end
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read data mux
	// The flag and lock bits read zero in manual mode, as software expects.
	// Loss detect is only meaningful with the VCO selected, zero otherwise.
	// The value is captured into the read data register at the address edge.
	always_comb begin
		rd_value = 32'h0;
		unique case (rd_idx)
			CTRL_IDX: begin
				rd_value[CTRL_IE_BIT] = ctrl_r.irq_en;
				rd_value[CTRL_FLAG_BIT] = ctrl_r.flag && auto_r;
				rd_value[CTRL_EN_BIT] = ctrl_r.pll_en;
				rd_value[CTRL_BCS_BIT] = ctrl_r.base_clock_select;
				rd_value[3:0] = CTRL_LOW_RD;
			end
			BWC_IDX: begin
				rd_value[BWC_AUTO_BIT] = auto_r;
				rd_value[BWC_LOCK_BIT] = lock_r && auto_r;
				rd_value[BWC_ACQ_BIT] = auto_r ? track_r : acq_man_r;
				rd_value[BWC_XLD_BIT] = xld_r && ctrl_r.base_clock_select;
			end
			PROG_IDX: begin
				rd_value[7:0] = prog_r;
			end
			STAT_IDX: begin
				rd_value[3:0] = feedback_multiplier;
				rd_value[4] = pll_active;
				rd_value[5] = osc_d_r;
			end
			default: begin
				rd_value = 32'h0;
			end
		endcase
	end

	// Read answer, one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (do_read) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_value;
			s_axi_rresp <= mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Control register: enable, select, interrupt enable
	// Enable and select each check the other's old value, so one write clearing enable and setting select leaves the VCO chosen while off.
	// Turning on and selecting the VCO therefore takes two separate writes.
	// A zero range or a stop request overrides any write to the select bit.
	// The interrupt enable cannot be set in manual mode and is cleared there.
	// Later assignments in this process win, so the overrides sit last.
	// Wait mode has no input here, so nothing changes on it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r.pll_en <= EN_RST;
			ctrl_r.base_clock_select <= 1'b0;
			ctrl_r.irq_en <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				// Enable cannot drop while select is set
				ctrl_r.pll_en <= wdata_r[CTRL_EN_BIT] || ctrl_r.base_clock_select;
				// Select needs enable already on and a nonzero range; lock not checked
				ctrl_r.base_clock_select <= wdata_r[CTRL_BCS_BIT] && ctrl_r.pll_en
					&& (prog_r.vrs != 4'h0);
				ctrl_r.irq_en <= wdata_r[CTRL_IE_BIT] && auto_r;
			end
			if (!auto_r) begin
				ctrl_r.irq_en <= 1'b0;
			end
			if (prog_r.vrs == 4'h0) begin
				ctrl_r.base_clock_select <= 1'b0;
			end
			if (stop_entry || !oscillator_enable_in) begin
				ctrl_r.base_clock_select <= 1'b0;
			end
		end
	end

	// Lock-change flag: set wins over a clearing read
	// A lock change in the same cycle as a clearing read must not be lost,
	// or software would miss the transition that raised the request.
	// In break with clear enable low the read leaves the flag alone.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r.flag <= 1'b0;
		end else if (lock_change) begin
			ctrl_r.flag <= 1'b1;
		end else if (rd_clear) begin
			ctrl_r.flag <= 1'b0;
		end
	end

	// Program register, frozen while the PLL is on
	// Changing divider or range under a running loop would upset lock,
	// so software must turn the loop off before reprogramming.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_r.mul <= MUL_RST;
			prog_r.vrs <= VRS_RST;
		end else if (wr_prog && !ctrl_r.pll_en) begin
			prog_r.mul <= wdata_r[PROG_MUL_LSB+:4];
			prog_r.vrs <= wdata_r[PROG_VRS_LSB+:4];
		end
	end

	// Bandwidth register: mode, manual tracking value, loss detect
	// The manual tracking value is kept while in automatic mode
	// and shows again once manual mode resumes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			auto_r <= 1'b0;
			acq_man_r <= 1'b0;
			xld_r <= 1'b0;
		end else if (wr_bwc) begin
			auto_r <= wdata_r[BWC_AUTO_BIT];
			if (!auto_r) begin
				acq_man_r <= wdata_r[BWC_ACQ_BIT];
			end
			xld_r <= wdata_r[BWC_XLD_BIT] && !osc_d_r;
		end
	end

	// Automatic loop status from the tolerance comparators
	// Status is forced low in manual mode or with the loop off, so
	// turning automatic mode on afterwards with the loop within lock tolerance is itself seen as a lock change.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			track_r <= 1'b0;
			lock_r <= 1'b0;
			lock_d_r <= 1'b0;
		end else begin
			track_r <= auto_r && pll_active && pin_f_r[1];
			lock_r <= auto_r && pll_active && pin_f_r[0];
			lock_d_r <= lock_r;
		end
	end

	// ==========================================================
	// Outputs
	// Feedback and range settings, loop activity, stop tracking
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			feedback_multiplier <= 4'h1;
			vco_range_out <= 4'h0;
			pll_active <= 1'b0;
			osc_d_r <= 1'b0;
			crystal_clock_gate <= 1'b0;
		end else begin
			feedback_multiplier <= vco_factor(prog_r.mul);
			vco_range_out <= prog_r.vrs;
			pll_active <= ctrl_r.pll_en && (prog_r.vrs != 4'h0)
				&& oscillator_enable_in;
			osc_d_r <= oscillator_enable_in;
			crystal_clock_gate <= oscillator_enable_in;
		end
	end

	// Base clock: toggle per source cycle, held low in stop
	// With the crystal selected the bus clock itself is the source.
	// With the VCO selected only synced rising edges of the VCO count.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vco_d_r <= 1'b0;
			half_r <= 1'b0;
		end else begin
			vco_d_r <= pin_f_r[2];
			if (!oscillator_enable_in) begin
				half_r <= 1'b0;
			end else if (!ctrl_r.base_clock_select || (pin_f_r[2] && !vco_d_r)) begin
				half_r <= !half_r;
			end
		end
	end
	assign base_clock_out = half_r;

	// Interrupt request level
	// A level, not a pulse: it stays up until software clears the flag
	// or the enable, and drops one clock after the oscillator stops.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_irq_request <= 1'b0;
		end else begin
			pll_irq_request <= ctrl_r.flag && ctrl_r.irq_en && auto_r
				&& oscillator_enable_in;
		end
	end

endmodule // pll_ctl

// ===== test/pll_ctl_monitor.sv
`timescale 1ns/10ps
module pll_ctl_monitor
	import pll_ctl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic oscillator_enable_in,
	input wire logic [3:0] feedback_multiplier,
	input wire logic [3:0] vco_range_out,
	input wire logic pll_active,
	input wire logic crystal_clock_gate,
	input wire logic base_clock_out,
	input wire logic pll_irq_request
);
	// ==========================================================
	// Checks on outputs
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_stop_irq; !oscillator_enable_in |=> !pll_irq_request; endproperty
	a_stop_irq: assert property (p_stop_irq) else $error("irq high in stop");
	property p_stop_out; !oscillator_enable_in |=> !base_clock_out && !crystal_clock_gate; endproperty
	a_stop_out: assert property (p_stop_out) else $error("clock high in stop");
	property p_mul_nz; feedback_multiplier != 4'h0; endproperty
	a_mul_nz: assert property (p_mul_nz) else $error("factor zero");
	property p_mul_hold; pll_active |=> $stable(feedback_multiplier); endproperty
	a_mul_hold: assert property (p_mul_hold) else $error("factor moved");
	property p_vrs_hold; pll_active |=> $stable(vco_range_out); endproperty
	a_vrs_hold: assert property (p_vrs_hold) else $error("range moved");
	property p_zero_rng; vco_range_out == 4'h0 |-> !pll_active; endproperty
	a_zero_rng: assert property (p_zero_rng) else $error("active at range zero");
	property p_rst_val; $rose(aresetn) |=> feedback_multiplier == MUL_RST && vco_range_out == VRS_RST; endproperty
	a_rst_val: assert property (p_rst_val) else $error("bad reset value");
	property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("late read answer");
	property p_wr_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("late write answer");
endmodule // pll_ctl_monitor

// ===== test/sim_side_model.sv
`timescale 1ns/10ps
module sim_side_model (
	input wire logic aclk,
	input wire logic stop_req,
	input wire logic trk_req,
	input wire logic lk_req,
	input wire logic pll_active,
	output logic oscillator_enable_in,
	output logic vco_clock,
	output logic within_tracking_tol,
	output logic within_lock_tol
);
	logic [1:0] cnt = 2'h0;
	// VCO runs only while the loop is on, stands low otherwise
	always @(posedge aclk) cnt <= cnt + 2'h1;
	assign vco_clock = pll_active & cnt[1];
	// Stop request drops the oscillator enable
	assign oscillator_enable_in = !stop_req;
	// Loop error lies within tolerance only while running
	assign within_tracking_tol = trk_req & pll_active;
	assign within_lock_tol = lk_req & pll_active;
endmodule // sim_side_model

// ===== test/pll_ctl_tb_top.sv
`timescale 1ns/10ps
module pll_ctl_tb_top;
	import pll_ctl_pkg::*;
	typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_s;
	logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0, break_state_in = '0, break_clear_enable = '0;
	logic stop_req = '0, trk_req = '0, lk_req = '0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, oscillator_enable_in, vco_clock, within_tracking_tol;
	logic within_lock_tol, pll_active, crystal_clock_gate, base_clock_out, pll_irq_request;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, got;
	logic [3:0] s_axi_wstrb = 4'hF, feedback_multiplier, vco_range_out;
	logic [1:0] s_axi_bresp, s_axi_rresp, bgot, rgot, ex;
	int errors = 0, compares = 0;
	row_s rows [25] = '{'{1'h0,8'h70,8'h00,8'h2F}, '{1'h0,8'h78,8'h00,8'h66},
		'{1'h0,8'h74,8'h00,8'h00}, '{1'h1,8'h78,8'h35,8'h66}, '{1'h1,8'h70,8'h00,8'h0F},
		'{1'h1,8'h78,8'h05,8'h05}, '{1'h0,8'h80,8'h00,8'h21}, '{1'h1,8'h78,8'hF6,8'hF6},
		'{1'h0,8'h80,8'h00,8'h2F}, '{1'h1,8'h70,8'h10,8'h0F}, '{1'h1,8'h70,8'h20,8'h2F},
		'{1'h1,8'h70,8'h30,8'h3F}, '{1'h1,8'h70,8'h10,8'h3F}, '{1'h1,8'h70,8'h00,8'h2F},
		'{1'h1,8'h70,8'h00,8'h0F}, '{1'h1,8'h78,8'hF0,8'hF0}, '{1'h1,8'h70,8'h20,8'h2F},
		'{1'h1,8'h70,8'h30,8'h2F}, '{1'h0,8'h80,8'h00,8'h2F}, '{1'h1,8'h70,8'h00,8'h0F},
		'{1'h1,8'h78,8'h66,8'h66}, '{1'h1,8'h70,8'h20,8'h2F}, '{1'h0,8'h7C,8'h00,8'h00},
		'{1'h1,8'h90,8'h05,8'h00}, '{1'h1,8'h74,8'h80,8'h80}};
	pll_ctl dut (.*);
	sim_side_model far_side (.*);
	always #12.5 aclk = ~aclk;
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, g, x);
		end
	endtask
	task automatic report_and_stop();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Write cycle: both channels offered together, response awaited
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= {2'h0, a};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do @(posedge aclk); while (!(s_axi_awready === 1'h1 && s_axi_wready === 1'h1));
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
		bgot = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	// Read cycle, data kept in got
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= {2'h0, a};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
		got = s_axi_rdata;
		rgot = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(got, {24'h0, e});
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Watchdog cuts a hung run short
	initial begin
		#(25 * 8000);
		errors++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		wt(12);
		aresetn <= 1'h1;
		foreach (rows[i]) begin
			ex = (rows[i].a inside {8'h70, 8'h74, 8'h78, 8'h80}) ? RESP_OKAY : RESP_SLVERR;
			if (rows[i].w) begin
				wr(rows[i].a, rows[i].d);
				chk({30'h0, bgot}, {30'h0, ex});
			end
			rc(rows[i].a, rows[i].e);
			chk({30'h0, rgot}, {30'h0, ex});
		end
		wr(8'h70, 8'hA0);
		trk_req <= 1'h1;
		lk_req <= 1'h1;
		wt(20);
		chk({31'h0, pll_irq_request}, 32'h1);
		rc(8'h74, 8'hE0);
		rc(8'h70, 8'hEF);
		wt(3);
		chk({31'h0, pll_irq_request}, 32'h0);
		trk_req <= 1'h0;
		lk_req <= 1'h0;
		wt(20);
		break_state_in <= 1'h1;
		rc(8'h70, 8'hEF);
		rc(8'h70, 8'hEF);
		break_clear_enable <= 1'h1;
		rc(8'h70, 8'hEF);
		rc(8'h70, 8'hAF);
		break_state_in <= 1'h0;
		rc(8'h70, 8'hAF);
		trk_req <= 1'h1;
		lk_req <= 1'h1;
		wt(20);
		wr(8'h74, 8'h00);
		rc(8'h70, 8'h2F);
		chk({31'h0, pll_irq_request}, 32'h0);
		wr(8'h74, 8'h80);
		wt(20);
		rc(8'h70, 8'h6F);
		chk({31'h0, pll_irq_request}, 32'h0);
		trk_req <= 1'h0;
		lk_req <= 1'h0;
		wr(8'h74, 8'h00);
		wr(8'h70, 8'h30);
		stop_req <= 1'h1;
		wt(10);
		chk({30'h0, base_clock_out, crystal_clock_gate}, 32'h0);
		stop_req <= 1'h0;
		wt(10);
		rc(8'h70, 8'h2F);
		wr(8'h70, 8'h00);
		aresetn <= 1'h0;
		wt(12);
		aresetn <= 1'h1;
		rc(8'h70, 8'h2F);
		got[0] = base_clock_out;
		wt(1);
		chk({31'h0, base_clock_out}, {31'h0, ~got[0]});
		report_and_stop();
	end
endmodule // pll_ctl_tb_top
bind pll_ctl pll_ctl_monitor mon (.*);
